// [t3crb_pkg.sv]
// constants for the split-capable reload/capture timer
package t3crb_pkg;
  localparam logic [7:0] T3CRB_RELOAD_LOW_ADDR  = 8'hba;
  localparam logic [7:0] T3CRB_RELOAD_HIGH_ADDR = 8'hbb;
  localparam logic [7:0] T3CRB_COUNT_LOW_ADDR   = 8'hbc;
  localparam logic [7:0] T3CRB_COUNT_HIGH_ADDR  = 8'hbd;
  localparam logic [7:0] T3CRB_BYTE_RESET       = 8'h00;
  localparam logic [7:0] T3CRB_BYTE_ONES        = 8'hff;
  localparam logic [7:0] T3CRB_BYTE_ONE         = 8'h01;
  localparam logic [7:0] T3CRB_UNMAPPED_READ    = 8'h00;
endpackage

// [t3crb_timer.sv]
// split-capable 16-bit timer with reload/capture bytes on the sfr bus
//
// Operation
// - reload/capture low byte, read-write at 0xba
// - reload bytes written take effect immediately
// - capture mode latches count into reload bytes
// - reload/capture high byte, read-write at 0xbb
// - wide mode: 0xbc is count bits 7:0
// - split mode: 0xbc is low counter
// - wide mode: 0xbd is count bits 15:8
// - split mode: 0xbd is high counter
// - split bit selects wide or independent halves
// - high flag set by overflow/capture, software-cleared
// - irq is high flag or enabled low flag
// - run bits enable their half or whole
`timescale 1ns/100ps
module t3crb_timer (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       split_halves_select_i,
  input  wire logic       low_half_run_i,
  input  wire logic       high_half_run_i,
  input  wire logic       low_half_capture_select_i,
  input  wire logic       high_half_capture_select_i,
  input  wire logic       low_half_irq_enable_i,
  input  wire logic       low_capture_event_i,
  input  wire logic       high_capture_event_i,
  input  wire logic       low_flag_clear_i,
  input  wire logic       high_flag_clear_i,
  output logic            low_half_event_flag_o,
  output logic            high_half_event_flag_o,
  output logic            timer_irq_o
);

  logic [7:0] reload_low_reg;
  logic [7:0] reload_low_next;
  logic [7:0] reload_high_reg;
  logic [7:0] reload_high_next;
  logic [7:0] count_low_reg;
  logic [7:0] count_low_next;
  logic [7:0] count_high_reg;
  logic [7:0] count_high_next;
  logic       low_flag_reg;
  logic       low_flag_next;
  logic       high_flag_reg;
  logic       high_flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] offset);
    sfr_hit = (addr == offset);
  endfunction

  logic wr_reload_low;
  logic wr_reload_high;
  logic wr_count_low;
  logic wr_count_high;

  assign wr_reload_low  = sfr_wr_i && sfr_hit(sfr_addr_i, t3crb_pkg::T3CRB_RELOAD_LOW_ADDR);
  assign wr_reload_high = sfr_wr_i && sfr_hit(sfr_addr_i, t3crb_pkg::T3CRB_RELOAD_HIGH_ADDR);
  assign wr_count_low   = sfr_wr_i && sfr_hit(sfr_addr_i, t3crb_pkg::T3CRB_COUNT_LOW_ADDR);
  assign wr_count_high  = sfr_wr_i && sfr_hit(sfr_addr_i, t3crb_pkg::T3CRB_COUNT_HIGH_ADDR);

  always_comb begin
    logic        low_wrap;
    logic        high_wrap;
    logic        set_low;
    logic        set_high;
    logic [15:0] wide_sum;
    low_wrap        = 1'b0;
    high_wrap       = 1'b0;
    set_low         = 1'b0;
    set_high        = 1'b0;
    wide_sum        = {count_high_reg, count_low_reg} + 16'h0001;
    reload_low_next  = reload_low_reg;
    reload_high_next = reload_high_reg;
    count_low_next   = count_low_reg;
    count_high_next  = count_high_reg;
    // no shadow copy: a write lands in the byte at once
    if (wr_reload_low) begin
      reload_low_next = sfr_wdata_i;
    end
    if (wr_reload_high) begin
      reload_high_next = sfr_wdata_i;
    end
    if (!split_halves_select_i) begin
      // wide: low-half controls govern the whole counter
      low_wrap  = low_half_run_i && (count_low_reg == t3crb_pkg::T3CRB_BYTE_ONES);
      high_wrap = low_wrap && (count_high_reg == t3crb_pkg::T3CRB_BYTE_ONES);
      if (low_half_run_i) begin
        {count_high_next, count_low_next} = wide_sum;
      end
      if (low_half_capture_select_i) begin
        // low flag acts as a 17th bit in wide capture
        set_low = high_wrap;
        if (low_capture_event_i) begin
          reload_low_next  = count_low_reg;
          reload_high_next = count_high_reg;
          set_high         = 1'b1;
        end
      end else begin
        set_low = low_wrap;
        if (high_wrap) begin
          count_low_next  = reload_low_reg;
          count_high_next = reload_high_reg;
          set_high        = 1'b1;
        end
      end
    end else begin
      low_wrap  = low_half_run_i && (count_low_reg == t3crb_pkg::T3CRB_BYTE_ONES);
      high_wrap = high_half_run_i && (count_high_reg == t3crb_pkg::T3CRB_BYTE_ONES);
      if (low_half_run_i) begin
        count_low_next = count_low_reg + t3crb_pkg::T3CRB_BYTE_ONE;
      end
      if (high_half_run_i) begin
        count_high_next = count_high_reg + t3crb_pkg::T3CRB_BYTE_ONE;
      end
      if (low_half_capture_select_i) begin
        if (low_capture_event_i) begin
          reload_low_next = count_low_reg;
          set_low         = 1'b1;
        end
      end else if (low_wrap) begin
        count_low_next = reload_low_reg;
        set_low        = 1'b1;
      end
      if (high_half_capture_select_i) begin
        if (high_capture_event_i) begin
          reload_high_next = count_high_reg;
          set_high         = 1'b1;
        end
      end else if (high_wrap) begin
        count_high_next = reload_high_reg;
        set_high        = 1'b1;
      end
    end
    // software writes to the count override counting in that cycle
    if (wr_count_low) begin
      count_low_next = sfr_wdata_i;
    end
    if (wr_count_high) begin
      count_high_next = sfr_wdata_i;
    end
    // set beats clear so an event in the clearing cycle survives
    low_flag_next  = set_low || (low_flag_reg && !low_flag_clear_i);
    high_flag_next = set_high || (high_flag_reg && !high_flag_clear_i);
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        t3crb_pkg::T3CRB_RELOAD_LOW_ADDR:  rdata_next = reload_low_reg;
        t3crb_pkg::T3CRB_RELOAD_HIGH_ADDR: rdata_next = reload_high_reg;
        t3crb_pkg::T3CRB_COUNT_LOW_ADDR:   rdata_next = count_low_reg;
        t3crb_pkg::T3CRB_COUNT_HIGH_ADDR:  rdata_next = count_high_reg;
        default:                           rdata_next = t3crb_pkg::T3CRB_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reload_low_reg  <= t3crb_pkg::T3CRB_BYTE_RESET;
      reload_high_reg <= t3crb_pkg::T3CRB_BYTE_RESET;
      count_low_reg   <= t3crb_pkg::T3CRB_BYTE_RESET;
      count_high_reg  <= t3crb_pkg::T3CRB_BYTE_RESET;
      low_flag_reg    <= 1'b0;
      high_flag_reg   <= 1'b0;
      rdata_reg       <= t3crb_pkg::T3CRB_BYTE_RESET;
    end else begin
      reload_low_reg  <= reload_low_next;
      reload_high_reg <= reload_high_next;
      count_low_reg   <= count_low_next;
      count_high_reg  <= count_high_next;
      low_flag_reg    <= low_flag_next;
      high_flag_reg   <= high_flag_next;
      rdata_reg       <= rdata_next;
    end
  end

  assign sfr_rdata_o            = rdata_reg;
  assign low_half_event_flag_o  = low_flag_reg;
  assign high_half_event_flag_o = high_flag_reg;
  assign timer_irq_o = high_flag_reg || (low_flag_reg && low_half_irq_enable_i);

endmodule

// [t3crb_props.sv]
// port-level assertions for the reload/capture timer
`timescale 1ns/100ps
module t3crb_props (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       low_half_run_i,
  input wire logic       high_half_run_i,
  input wire logic       low_half_irq_enable_i,
  input wire logic       low_capture_event_i,
  input wire logic       high_capture_event_i,
  input wire logic       low_flag_clear_i,
  input wire logic       high_flag_clear_i,
  input wire logic       low_half_event_flag_o,
  input wire logic       high_half_event_flag_o,
  input wire logic       timer_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic calm;
  // no counting and no capture, so written bytes must read back unchanged
  assign calm = !low_half_run_i && !high_half_run_i && !low_capture_event_i && !high_capture_event_i;
  property p_irq; timer_irq_o == (high_half_event_flag_o | (low_half_event_flag_o & low_half_irq_enable_i)); endproperty
  a_irq: assert property (p_irq) else $error("irq not flag combination");
  property p_rdbk; sfr_wr_i && calm ##1 sfr_rd_i && calm && $stable(sfr_addr_i) && sfr_addr_i inside {[8'hba:8'hbd]} |=> sfr_rdata_o == $past(sfr_wdata_i, 2); endproperty
  a_rdbk: assert property (p_rdbk) else $error("byte write not read back");
  property p_unmap; sfr_rd_i && !(sfr_addr_i inside {[8'hba:8'hbd]}) |=> sfr_rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_hkeep; high_half_event_flag_o && !high_flag_clear_i |=> high_half_event_flag_o; endproperty
  a_hkeep: assert property (p_hkeep) else $error("high flag lost");
  property p_lkeep; low_half_event_flag_o && !low_flag_clear_i |=> low_half_event_flag_o; endproperty
  a_lkeep: assert property (p_lkeep) else $error("low flag lost");
  property p_hclr; high_flag_clear_i && calm |=> !high_half_event_flag_o; endproperty
  a_hclr: assert property (p_hclr) else $error("high flag not cleared");
  property p_hrise; $rose(high_half_event_flag_o) |-> $past(!calm); endproperty
  a_hrise: assert property (p_hrise) else $error("high flag set without cause");
endmodule
bind t3crb_timer t3crb_props u_props (.*);

// [test_t3crb_timer.sv]
// self-checking bench for the reload/capture timer
`timescale 1ns/100ps
module test_t3crb_timer;
  logic       sys_clk_i=0, rstn_i=0, sfr_wr_i=0, sfr_rd_i=0, split_halves_select_i=0;
  logic       low_half_run_i=0, high_half_run_i=0, low_half_capture_select_i=0;
  logic       high_half_capture_select_i=0, low_half_irq_enable_i=0, low_capture_event_i=0;
  logic       high_capture_event_i=0, low_flag_clear_i=0, high_flag_clear_i=0;
  logic       low_half_event_flag_o, high_half_event_flag_o, timer_irq_o;
  logic [7:0] sfr_addr_i=0, sfr_wdata_i=0, sfr_rdata_o;
  int         err_count=0, num_checks=0;
  logic [7:0] rows [5][3] = '{'{8'hba,8'h5a,8'h5a}, '{8'hbb,8'ha5,8'ha5}, '{8'hbc,8'h3c,8'h3c},
                              '{8'hbd,8'hc3,8'hc3}, '{8'hbe,8'h77,8'h00}};
  t3crb_timer u_dut (.*);
  initial forever #10 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic idle;
    {sfr_wr_i, sfr_rd_i} = 2'b00;
    @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {sfr_addr_i, sfr_wdata_i, sfr_wr_i, sfr_rd_i} = {a, d, 2'b10};
    @(negedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    {sfr_addr_i, sfr_wr_i, sfr_rd_i} = {a, 2'b01};
    @(negedge sys_clk_i);
    chk(sfr_rdata_o, e);
  endtask
  task automatic wr4(input logic [7:0] rl, rh, cl, ch);
    wr(8'hba, rl);
    wr(8'hbb, rh);
    wr(8'hbc, cl);
    wr(8'hbd, ch);
  endtask
  // exactly one counting or capture edge
  task automatic pulse(ref logic s);
    s = 1;
    idle();
    s = 0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (12) @(negedge sys_clk_i);
    rstn_i = 1;
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
    end
    $display("register rows done");
    wr4(8'h34, 8'h12, 8'hff, 8'hff);
    pulse(low_half_run_i);
    rd(8'hbc, 8'h34);
    rd(8'hbd, 8'h12);
    chk({5'h0, low_half_event_flag_o, high_half_event_flag_o, timer_irq_o}, 8'h07);
    pulse(high_flag_clear_i);
    chk({5'h0, low_half_event_flag_o, high_half_event_flag_o, timer_irq_o}, 8'h04);
    low_half_irq_enable_i = 1;
    idle();
    chk({7'h0, timer_irq_o}, 8'h01);
    $display("wide overflow done");
    split_halves_select_i = 1;
    pulse(low_flag_clear_i);
    wr4(8'h56, 8'h00, 8'hff, 8'h10);
    pulse(low_half_run_i);
    pulse(high_half_run_i);
    rd(8'hbc, 8'h56);
    rd(8'hbd, 8'h11);
    chk({5'h0, low_half_event_flag_o, high_half_event_flag_o, timer_irq_o}, 8'h05);
    $display("split halves done");
    split_halves_select_i = 0;
    low_half_capture_select_i = 1;
    wr4(8'h00, 8'h00, 8'hcd, 8'hab);
    pulse(low_capture_event_i);
    rd(8'hba, 8'hcd);
    rd(8'hbb, 8'hab);
    $display("capture done");
    split_halves_select_i = 1;
    high_half_capture_select_i = 1;
    pulse(low_flag_clear_i);
    pulse(high_flag_clear_i);
    wr(8'hbc, 8'h21);
    wr(8'hbd, 8'h43);
    pulse(high_capture_event_i);
    rd(8'hbb, 8'h43);
    rd(8'hba, 8'hcd);
    chk({5'h0, low_half_event_flag_o, high_half_event_flag_o, timer_irq_o}, 8'h03);
    pulse(low_capture_event_i);
    rd(8'hba, 8'h21);
    chk({5'h0, low_half_event_flag_o, high_half_event_flag_o, timer_irq_o}, 8'h07);
    split_halves_select_i = 0;
    high_half_capture_select_i = 0;
    $display("split capture done");
    rstn_i = 0;
    idle();
    rstn_i = 1;
    for (int a = 'hba; a <= 'hbd; a++) rd(8'(a), 8'h00);
    chk({5'h0, low_half_event_flag_o, high_half_event_flag_o, timer_irq_o}, 8'h00);
    $display("reset done");
    wrap_up();
  end
endmodule
